/* File: design/otp_consts.svh */
`ifndef OTP_CONSTS_SVH
`define OTP_CONSTS_SVH

// Bus address map: oscillator group, then one group per loop
`define OTP_ADDR_W          8
`define OTP_OSC_BASE        8'h00
`define OTP_FLL_MID_BASE    8'h10
`define OTP_FLL_FAST_BASE   8'h18
`define OTP_GRP_MASK        8'hF8
`define OTP_OFS_MASK        8'h07

// Oscillator group offsets
`define OTP_SLOW_RC_TRIM_OFS   8'h04
`define OTP_PLL_SETUP_OFS      8'h05
`define OTP_LOOP_REF_OFS       8'h06

// Loop group offsets
`define OTP_FLL_CTRL_OFS       8'h00
`define OTP_FLL_FINE_OFS       8'h02
`define OTP_FLL_COARSE_OFS     8'h03
`define OTP_FLL_RATIO_LO_OFS   8'h05
`define OTP_FLL_RATIO_HI_OFS   8'h06

// Field positions
`define OTP_PLL_SRC_MSB     7
`define OTP_PLL_SRC_LSB     6
`define OTP_PLL_HALVE_BIT   5
`define OTP_PLL_FAC_MSB     4
`define OTP_FAST_REF_MSB    2
`define OTP_FAST_REF_LSB    1
`define OTP_MID_REF_BIT     0
`define OTP_FLL_EN_BIT      0

// Reset values
`define OTP_PLL_SETUP_RST   8'h00
`define OTP_LOOP_REF_RST    3'h0
`define OTP_RATIO_FAST_RST  16'h7A12
`define OTP_RATIO_MID_RST   16'h07A1

// Encodings
`define OTP_FAST_REF_SLOW_RC  2'h0
`define OTP_FAST_REF_XTAL     2'h1
`define OTP_FAST_REF_USB_SOF  2'h2

`endif

/* File: design/otp_pkg.sv */
package otp_pkg;
    typedef logic [7:0] otp_byte_t;
    typedef enum logic [1:0] {
        OTP_PLL_IN_MID_RC  = 2'h0,
        OTP_PLL_IN_RSVD    = 2'h1,
        OTP_PLL_IN_FAST_RC = 2'h2,
        OTP_PLL_IN_EXT_CLK = 2'h3
    } otp_pll_src_e;
endpackage

/* File: design/otp_osc_trim_cfg.sv */
// How it works
// - Reset loads factory trim into the slow oscillator trim register.
// - Software may rewrite the slow oscillator trim at any time.
// - Two-bit PLL source: 00 mid osc, 10 fast osc, 11 external, 01 reserved.
// - Divided-output bit, bit 5, halves the PLL output.
// - Five-bit multiply field sets factor 1x to 31x.
// - Fast loop reference: 00 slow osc, 01 watch crystal, 10 USB frame.
// - Mid loop reference bit resets to zero; one picks watch crystal.
// - Enable bit 0 starts the loop and run-time calibration.
// - Enable reads one until the loop has really stopped.
// - Coarse and fine fields form a 13-bit trim; manual when loop off.
// - Seven-bit fine field loads from factory and is auto-adjusted.
// - Calibration writes are ignored while the loop is enabled.
// - Six-bit coarse field loads from factory, untouched by the loop.
// - Compare value holds target ratio; fast loop resets to 0x7A12.
// - Compare low byte at offset 5, high byte at offset 6.
`timescale 1ns/10ps
`include "otp_consts.svh"

module otp_osc_trim_cfg
    import otp_pkg::*;
#(
    parameter int          CNT_W         = 16,
    parameter logic [15:0] RATIO_MID_RST = `OTP_RATIO_MID_RST
) (
    input  wire logic        i_sys_clk,               // System clock
    input  wire logic        i_rst_n,                 // Synchronous reset, active low
    input  wire logic [7:0]  i_addr,                  // Register byte address
    input  wire logic [7:0]  i_wdata,                 // Write data
    input  wire logic        i_wr,                    // Write strobe
    input  wire logic        i_rd,                    // Read strobe
    output logic      [7:0]  o_rdata,                 // Read data, cycle after strobe
    input  wire logic [7:0]  i_sig_slow_rc_trim,      // Factory slow osc trim
    input  wire logic [6:0]  i_sig_fine_trim [2],     // Factory fine trim, 0 mid 1 fast
    input  wire logic [5:0]  i_sig_coarse_trim [2],   // Factory coarse trim
    input  wire logic        i_osc_tick [2],          // Tick per loop oscillator cycle
    input  wire logic        i_slow_rc_tick,          // Slow osc reference tick
    input  wire logic        i_watch_crystal_tick,    // Watch crystal reference tick
    input  wire logic        i_usb_frame_start_tick,  // USB frame start tick
    output logic      [7:0]  o_slow_rc_trim_value,    // Slow osc trim
    output logic      [1:0]  o_pll_input_select,      // PLL input source
    output logic             o_pll_halve_output,      // Halve PLL output
    output logic      [4:0]  o_pll_multiply_factor,   // PLL multiply factor
    output logic      [1:0]  o_fast_rc_loop_reference, // Fast loop reference
    output logic             o_mid_rc_loop_reference, // Mid loop reference
    output logic      [12:0] o_fll_trim [2],          // Coarse and fine trim word
    output logic             o_fll_active [2]         // Loop running
);

    logic [7:0]  slow_trim_ff;
    otp_byte_t   pll_setup_ff;
    logic [2:0]  loop_ref_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        en_ff      [2];
    logic        run_ff     [2];
    logic        primed_ff  [2];
    logic [6:0]  fine_ff    [2];
    logic [5:0]  coarse_ff  [2];
    logic [15:0] ratio_ff   [2];
    logic [CNT_W-1:0] cnt_ff [2];
    logic        ref_tick   [2];
    logic        grp_hit    [2];

    wire logic [7:0] ofs = i_addr & `OTP_OFS_MASK;
    wire logic       osc_hit = (i_addr & `OTP_GRP_MASK) == `OTP_OSC_BASE;
    assign grp_hit[0] = (i_addr & `OTP_GRP_MASK) == `OTP_FLL_MID_BASE;
    assign grp_hit[1] = (i_addr & `OTP_GRP_MASK) == `OTP_FLL_FAST_BASE;

    // Oscillator group registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            slow_trim_ff <= i_sig_slow_rc_trim;
        end else if (i_wr && osc_hit && ofs == `OTP_SLOW_RC_TRIM_OFS) begin
            slow_trim_ff <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            pll_setup_ff <= `OTP_PLL_SETUP_RST;
        end else if (i_wr && osc_hit && ofs == `OTP_PLL_SETUP_OFS) begin
            pll_setup_ff <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            loop_ref_ff <= `OTP_LOOP_REF_RST;
        end else if (i_wr && osc_hit && ofs == `OTP_LOOP_REF_OFS) begin
            loop_ref_ff <= i_wdata[2:0];
        end
    end

    // Reference routing per loop
    always_comb begin
        ref_tick[0] = loop_ref_ff[`OTP_MID_REF_BIT] ? i_watch_crystal_tick
                                                    : i_slow_rc_tick;
        unique case (loop_ref_ff[`OTP_FAST_REF_MSB:`OTP_FAST_REF_LSB])
            `OTP_FAST_REF_SLOW_RC: ref_tick[1] = i_slow_rc_tick;
            `OTP_FAST_REF_XTAL:    ref_tick[1] = i_watch_crystal_tick;
            `OTP_FAST_REF_USB_SOF: ref_tick[1] = i_usb_frame_start_tick;
            default:               ref_tick[1] = 1'b0;
        endcase
    end

    generate
        for (genvar g = 0; g < 2; g++) begin : g_fll
            logic busy;
            logic wr_here;
            assign busy    = en_ff[g] | run_ff[g];
            assign wr_here = i_wr && grp_hit[g];

            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_n) begin
                    en_ff[g] <= 1'b0;
                end else if (wr_here && ofs == `OTP_FLL_CTRL_OFS) begin
                    en_ff[g] <= i_wdata[`OTP_FLL_EN_BIT];
                end
            end

            // After its first reference tick, loop stays running until the current reference period closes
            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_n) begin
                    run_ff[g] <= 1'b0;
                end else if (en_ff[g]) begin
                    run_ff[g] <= 1'b1;
                end else if (ref_tick[g] || !primed_ff[g]) begin
                    run_ff[g] <= 1'b0;
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_n || !run_ff[g]) begin
                    primed_ff[g] <= 1'b0;
                end else if (ref_tick[g]) begin
                    primed_ff[g] <= 1'b1;
                end
            end

            // Oscillator ticks within one reference period, saturating
            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_n || !run_ff[g] || ref_tick[g]) begin
                    cnt_ff[g] <= '0;
                end else if (i_osc_tick[g] && cnt_ff[g] != '1) begin
                    cnt_ff[g] <= cnt_ff[g] + 1'b1;
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_n) begin
                    fine_ff[g] <= i_sig_fine_trim[g];
                end else if (run_ff[g] && primed_ff[g] && ref_tick[g]) begin
                    if (CNT_W'(ratio_ff[g]) > cnt_ff[g] && fine_ff[g] != 7'h7F) begin
                        fine_ff[g] <= fine_ff[g] + 7'h01;
                    end else if (CNT_W'(ratio_ff[g]) < cnt_ff[g] && fine_ff[g] != 7'h00) begin
                        fine_ff[g] <= fine_ff[g] - 7'h01;
                    end
                end else if (wr_here && !busy && ofs == `OTP_FLL_FINE_OFS) begin
                    fine_ff[g] <= i_wdata[6:0];
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_n) begin
                    coarse_ff[g] <= i_sig_coarse_trim[g];
                end else if (wr_here && !busy && ofs == `OTP_FLL_COARSE_OFS) begin
                    coarse_ff[g] <= i_wdata[5:0];
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_n) begin
                    ratio_ff[g] <= (g == 1) ? `OTP_RATIO_FAST_RST : RATIO_MID_RST;
                end else if (wr_here && ofs == `OTP_FLL_RATIO_LO_OFS) begin
                    ratio_ff[g][7:0] <= i_wdata;
                end else if (wr_here && ofs == `OTP_FLL_RATIO_HI_OFS) begin
                    ratio_ff[g][15:8] <= i_wdata;
                end
            end

            assign o_fll_trim[g]   = {coarse_ff[g], fine_ff[g]};
            assign o_fll_active[g] = run_ff[g];
        end
    endgenerate

    // Read path, reserved bits as zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (osc_hit) begin
            unique case (ofs)
                `OTP_SLOW_RC_TRIM_OFS: nxt_rdata = slow_trim_ff;
                `OTP_PLL_SETUP_OFS:    nxt_rdata = pll_setup_ff;
                `OTP_LOOP_REF_OFS:     nxt_rdata = {5'h00, loop_ref_ff};
                default:               nxt_rdata = 8'h00;
            endcase
        end
        for (int k = 0; k < 2; k++) begin
            if (grp_hit[k]) begin
                unique case (ofs)
                    `OTP_FLL_CTRL_OFS:     nxt_rdata = {7'h00, en_ff[k] | run_ff[k]};
                    `OTP_FLL_FINE_OFS:     nxt_rdata = {1'b0, fine_ff[k]};
                    `OTP_FLL_COARSE_OFS:   nxt_rdata = {2'h0, coarse_ff[k]};
                    `OTP_FLL_RATIO_LO_OFS: nxt_rdata = ratio_ff[k][7:0];
                    `OTP_FLL_RATIO_HI_OFS: nxt_rdata = ratio_ff[k][15:8];
                    default:               nxt_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || !i_rd) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata                  = rdata_ff;
    assign o_slow_rc_trim_value     = slow_trim_ff;
    assign o_pll_input_select       = pll_setup_ff[`OTP_PLL_SRC_MSB:`OTP_PLL_SRC_LSB];
    assign o_pll_halve_output       = pll_setup_ff[`OTP_PLL_HALVE_BIT];
    assign o_pll_multiply_factor    = pll_setup_ff[`OTP_PLL_FAC_MSB:0];
    assign o_fast_rc_loop_reference = loop_ref_ff[`OTP_FAST_REF_MSB:`OTP_FAST_REF_LSB];
    assign o_mid_rc_loop_reference  = loop_ref_ff[`OTP_MID_REF_BIT];

endmodule

/* File: test/otp_osc_model.sv */
`timescale 1ns/10ps
module otp_osc_model (
    input  wire logic i_sys_clk,              // System clock
    input  wire logic i_rst_n,                // Sync reset, active low
    input  wire logic i_slow,                 // Halve the mid oscillator tick rate
    output logic      o_osc_tick [2],         // Loop oscillator ticks
    output logic      o_slow_rc_tick,         // Slow osc reference
    output logic      o_watch_crystal_tick,   // Watch crystal reference
    output logic      o_usb_frame_start_tick  // USB frame start reference
);
    logic [7:0] cnt_ff;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) cnt_ff <= 8'h00;
        else cnt_ff <= cnt_ff + 8'h01;
    end
    // References run from reset release on, before any loop is enabled
    assign o_slow_rc_tick = i_rst_n && cnt_ff[4:0] == 5'h1F;
    assign o_watch_crystal_tick = i_rst_n && cnt_ff[5:0] == 6'h3F;
    assign o_usb_frame_start_tick = i_rst_n && cnt_ff == 8'hFF;
    assign o_osc_tick[0] = i_rst_n && (!i_slow || cnt_ff[0]);
    assign o_osc_tick[1] = i_rst_n;
endmodule

/* File: test/otp_osc_trim_cfg_properties.sv */
`timescale 1ns/10ps
module otp_osc_trim_cfg_properties (
    input wire logic        i_sys_clk,                // System clock
    input wire logic        i_rst_n,                  // Sync reset, active low
    input wire logic        i_wr,                     // Write strobe
    input wire logic        i_rd,                     // Read strobe
    input wire logic [7:0]  i_addr,                   // Register address
    input wire logic [7:0]  i_wdata,                  // Write data
    input wire logic [7:0]  o_rdata,                  // Read data
    input wire logic [7:0]  o_slow_rc_trim_value,     // Slow osc trim
    input wire logic [1:0]  o_pll_input_select,       // PLL source
    input wire logic [1:0]  o_fast_rc_loop_reference, // Fast loop reference
    input wire logic        o_pll_halve_output,       // PLL halve
    input wire logic        o_mid_rc_loop_reference,  // Mid loop reference
    input wire logic [4:0]  o_pll_multiply_factor,    // PLL factor
    input wire logic [12:0] o_fll_trim [2],           // Loop trim words
    input wire logic        o_fll_active [2]          // Loop running
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
    chk_slow_trim_wr: assert property (i_wr && i_addr == 8'h04
        |=> o_slow_rc_trim_value == $past(i_wdata)) else $error("slow trim not written");
    chk_pll_fields: assert property (i_wr && i_addr == 8'h05 |=>
        {o_pll_input_select, o_pll_halve_output, o_pll_multiply_factor} == $past(i_wdata))
        else $error("pll fields wrong");
    chk_loop_ref: assert property (i_wr && i_addr == 8'h06 |=>
        {o_fast_rc_loop_reference, o_mid_rc_loop_reference} == $past(i_wdata[2:0]))
        else $error("loop reference wrong");
    chk_ref_readback: assert property (i_rd && i_addr == 8'h06 |=> o_rdata ==
        {5'h00, $past(o_fast_rc_loop_reference), $past(o_mid_rc_loop_reference)})
        else $error("reference readback wrong");
    chk_run_start: assert property (i_wr && i_addr == 8'h18 && i_wdata[0]
        |=> ##[0:1] o_fll_active[1]) else $error("loop did not start");
    chk_busy_read: assert property (o_fll_active[1] && i_rd && i_addr == 8'h18
        |=> o_rdata == 8'h01) else $error("enable not read as one");
    chk_coarse_hold: assert property (!(i_wr && i_addr == 8'h1B)
        |=> $stable(o_fll_trim[1][12:7])) else $error("coarse trim moved");
    chk_fine_step: assert property (o_fll_active[1] |=> 7'(o_fll_trim[1][6:0] -
        $past(o_fll_trim[1][6:0])) inside {7'h00, 7'h01, 7'h7F})
        else $error("fine trim jumped");
    cover property (i_wr && i_addr == 8'h18 && i_wdata[0]);
    cover property ($fell(o_fll_active[1]));
    cover property (o_fll_active[0] && $changed(o_fll_trim[0][6:0]));
endmodule
bind otp_osc_trim_cfg otp_osc_trim_cfg_properties u_chk (.i_sys_clk, .i_rst_n, .i_wr, .i_rd,
    .i_addr, .i_wdata, .o_rdata, .o_slow_rc_trim_value, .o_pll_input_select,
    .o_fast_rc_loop_reference, .o_pll_halve_output, .o_mid_rc_loop_reference,
    .o_pll_multiply_factor, .o_fll_trim, .o_fll_active);

/* File: test/tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
    typedef struct {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} otp_row_s;
    logic        clk, rst_n, wr, rd, slow, t_slow, t_xtal, t_usb, halve, mref;
    logic [7:0]  addr, wdata, rdata, sig_slow, trim_slow, d;
    logic [6:0]  sig_fine [2];
    logic [5:0]  sig_coarse [2];
    logic [12:0] trim [2];
    logic        osc_tick [2];
    logic        act [2];
    logic [1:0]  psel, fref;
    logic [4:0]  fac;
    int          mismatches, n_checks;
    // Reset values first, then write and read back; reserved bits written zero
    otp_row_s rows [26] = '{'{8'h04,0,0,8'h9C}, '{8'h05,0,0,8'h00}, '{8'h06,0,0,8'h00},
        '{8'h18,0,0,8'h00}, '{8'h1A,0,0,8'h35}, '{8'h1B,0,0,8'h2C}, '{8'h12,0,0,8'h11},
        '{8'h1D,0,0,8'h12}, '{8'h1E,0,0,8'h7A}, '{8'h15,0,0,8'hA1}, '{8'h16,0,0,8'h07},
        '{8'h04,1,8'h5A,8'h5A}, '{8'h05,1,8'hC3,8'hC3}, '{8'h05,1,8'hBF,8'hBF},
        '{8'h05,1,8'h01,8'h01}, '{8'h05,1,8'h5F,8'h5F}, '{8'h06,1,8'h05,8'h05},
        '{8'h06,1,8'h03,8'h03}, '{8'h1B,1,8'h2A,8'h2A}, '{8'h1A,1,8'h40,8'h40},
        '{8'h1D,1,8'hFF,8'hFF}, '{8'h1E,1,8'hFF,8'hFF}, '{8'h15,1,8'h00,8'h00},
        '{8'h16,1,8'h00,8'h00}, '{8'h07,1,8'h55,8'h00}, '{8'h1C,1,8'h55,8'h00}};
    otp_osc_model u_osc (.i_sys_clk(clk), .i_rst_n(rst_n), .i_slow(slow),
        .o_osc_tick(osc_tick), .o_slow_rc_tick(t_slow), .o_watch_crystal_tick(t_xtal),
        .o_usb_frame_start_tick(t_usb));
    otp_osc_trim_cfg dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sig_slow_rc_trim(sig_slow),
        .i_sig_fine_trim(sig_fine), .i_sig_coarse_trim(sig_coarse), .i_osc_tick(osc_tick),
        .i_slow_rc_tick(t_slow), .i_watch_crystal_tick(t_xtal),
        .i_usb_frame_start_tick(t_usb), .o_slow_rc_trim_value(trim_slow),
        .o_pll_input_select(psel), .o_pll_halve_output(halve), .o_pll_multiply_factor(fac),
        .o_fast_rc_loop_reference(fref), .o_mid_rc_loop_reference(mref),
        .o_fll_trim(trim), .o_fll_active(act));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // Waits up to 200 cycles for the loop active flag to drop, then checks it is zero
    task automatic wait_idle(input int k);
        for (int n = 0; n < 200 && act[k] !== 1'b0; n++) @(posedge clk);
        `CHK("loop_idle", 1'b0, act[k])
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #100000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        {rst_n, wr, rd, slow, addr, wdata} = '0;
        sig_slow = 8'h9C;
        sig_fine = '{7'h11, 7'h35};
        sig_coarse = '{6'h0C, 6'h2C};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, d);
            `CHK("reg", rows[i].e, d)
            if (rows[i].a == 8'h04) `CHK("slow_pin", rows[i].e, trim_slow)
            if (rows[i].a == 8'h05) `CHK("pll_pins", rows[i].e, {psel, halve, fac})
            if (rows[i].a == 8'h06) `CHK("ref_pins", rows[i].e, {5'h00, fref, mref})
        end
        // Reserved fast reference: loop runs but never steps
        wr_reg(8'h06, 8'h06);
        wr_reg(8'h18, 8'h01);
        repeat (300) @(posedge clk);
        wr_reg(8'h1B, 8'h15);
        wr_reg(8'h1A, 8'h10);
        @(negedge clk);
        `CHK("fine_noref", 7'h40, trim[1][6:0])
        `CHK("coarse_lock", 6'h2A, trim[1][12:7])
        wr_reg(8'h06, 8'h00);
        repeat (200) @(posedge clk);
        `CHK("fine_up", 1'b1, trim[1][6:0] > 7'h40)
        @(posedge clk iff t_slow);
        wr_reg(8'h18, 8'h00);
        rd_reg(8'h18, d);
        `CHK("busy_read", 8'h01, d)
        wait_idle(1);
        rd_reg(8'h18, d);
        `CHK("ctrl_off", 8'h00, d)
        slow <= 1'b1;
        wr_reg(8'h06, 8'h01);
        wr_reg(8'h10, 8'h01);
        repeat (300) @(posedge clk);
        `CHK("fine_down", 1'b1, trim[0][6:0] < 7'h11)
        wr_reg(8'h10, 8'h00);
        wait_idle(0);
        // Reset with both loops stopped reloads factory trims and compare value
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(8'h04, d);
        `CHK("slow_reload", 8'h9C, d)
        rd_reg(8'h12, d);
        `CHK("fine_reload", 8'h11, d)
        rd_reg(8'h1E, d);
        `CHK("ratio_reload", 8'h7A, d)
        // USB frame start as fast loop reference
        wr_reg(8'h06, 8'h04);
        wr_reg(8'h18, 8'h01);
        repeat (600) @(posedge clk);
        `CHK("fine_usb", 1'b1, trim[1][6:0] > 7'h35)
        // Reset while the loop runs stops it at once
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(8'h18, d);
        `CHK("ctrl_reset", 8'h00, d)
        `CHK("fine_reset", 7'h35, trim[1][6:0])
        report_and_stop;
    end
endmodule
